// File: core/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RES_LO = 8'h04;
  localparam logic [7:0] OFF_RES_HI = 8'h08;
  localparam logic [7:0] OFF_SFIO = 8'h0C;
  localparam logic [7:0] OFF_INSEL = 8'h10;
  localparam logic [7:0] OFF_PSTAT = 8'h14;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic power_on;
    logic conversion_start;
    logic auto_trigger_enable;
    logic completion_flag;
    logic completion_irq_enable;
    logic [2:0] clock_divider_select;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] ref_select;
    logic left_adjust;
    logic [4:0] channel_gain_select;
  } insel_t;

  typedef struct packed {
    logic [2:0] trigger_source_select;
    logic reserved_bit;
    logic [3:0] other_bits;
  } sfio_t;

  localparam int PSTAT_GIE_BIT = 0;

  // ---------------------------------------------------------------
  // Channel codes, trigger codes, timing
  // ---------------------------------------------------------------
  localparam logic [4:0] CH_DIFF_FIRST = 5'h08;
  localparam logic [4:0] CH_DIFF_LAST = 5'h1D;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam int FIRST_CONV_CYCLES = 25;
  localparam int NORMAL_CONV_CYCLES = 13;
  localparam int RESULT_W = 10;
  localparam int PRESC_W = 7;

endpackage : adc_seq_pkg
`default_nettype wire

// File: core/adc_sequencing_control.sv
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencing_control
  import adc_seq_pkg::*;
#(
  parameter int FIRST_CYCLES = FIRST_CONV_CYCLES,
  parameter int NORMAL_CYCLES = NORMAL_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:1] trig_in,
  input wire logic [RESULT_W-1:0] sar_result,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [4:0] analog_ch,
  output logic [1:0] analog_ref,
  output logic converting
);

  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
    logic [PRESC_W-1:0] m;
    m = '0;
    case (sel)
      3'h0, 3'h1: m = 7'h01;
      3'h2: m = 7'h03;
      3'h3: m = 7'h07;
      3'h4: m = 7'h0F;
      3'h5: m = 7'h1F;
      3'h6: m = 7'h3F;
      3'h7: m = 7'h7F;
      default: m = 7'h01;
    endcase
    return m;
  endfunction : div_mask

  function automatic logic is_diff(input logic [4:0] ch);
    return (ch >= CH_DIFF_FIRST) && (ch <= CH_DIFF_LAST);
  endfunction : is_diff

  localparam logic [4:0] FIRST_LEN = 5'(FIRST_CYCLES);
  localparam logic [4:0] NORMAL_LEN = 5'(NORMAL_CYCLES);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ctrl_t ctrl_q;
  insel_t insel_q;
  sfio_t sfio_q;
  logic gie_q;
  conv_state_t state_q;
  logic [4:0] cyc_q;
  logic [4:0] len_q;
  logic init_pend_q;
  logic [PRESC_W-1:0] presc_q;
  logic trig_prev_q;
  logic [RESULT_W-1:0] sar_s1_q;
  logic [RESULT_W-1:0] sar_s2_q;
  logic [RESULT_W-1:0] result_q;
  logic lock_q;
  logic [4:0] active_ch_q;
  logic [1:0] active_ref_q;

  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wen_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic wr_ctrl;
  ctrl_t wctrl;
  assign wr_fire = aw_have_q && w_have_q && !bvalid;
  assign rd_fire = arvalid && arready;
  assign wr_ctrl = wr_fire && wen_q && (awaddr_q == OFF_CTRL);
  assign wctrl = ctrl_t'(wbyte_q);

  // ---------------------------------------------------------------
  // Conversion control terms
  // ---------------------------------------------------------------
  logic tick;
  logic conv_done;
  logic sel_level;
  logic sw_start;
  logic auto_start;
  logic free_run;
  logic power_rise;
  logic start_now;

  assign tick = ctrl_q.power_on && ((presc_q & div_mask(ctrl_q.clock_divider_select))
                == div_mask(ctrl_q.clock_divider_select));
  assign conv_done = (state_q == ST_CONV) && ctrl_q.power_on && tick && (cyc_q == len_q - 5'd1);

  assign sel_level = (sfio_q.trigger_source_select == TRIG_FREE_RUN) ? 1'b0 :
                     trig_in[sfio_q.trigger_source_select];
  assign free_run = ctrl_q.auto_trigger_enable && (sfio_q.trigger_source_select == TRIG_FREE_RUN);

  assign sw_start = wr_ctrl && wctrl.conversion_start && wctrl.power_on;
  assign power_rise = wr_ctrl && wctrl.power_on && !ctrl_q.power_on;

  assign auto_start = ctrl_q.auto_trigger_enable && ctrl_q.power_on && sel_level && !trig_prev_q;
  assign start_now = (state_q == ST_IDLE) && (sw_start || auto_start);

  // ---------------------------------------------------------------
  // Prescaler and trigger edge history
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
    end else if (ce) begin
      if (ctrl_q.power_on) begin
        presc_q <= presc_q + 7'd1;
      end else begin
        presc_q <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_q <= 1'b0;
    end else if (ce) begin
      trig_prev_q <= sel_level;
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cyc_q <= '0;
      len_q <= NORMAL_LEN;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (start_now) begin
            state_q <= ST_CONV;
            cyc_q <= '0;
            len_q <= (init_pend_q || power_rise) ? FIRST_LEN : NORMAL_LEN;
          end
        end
        ST_CONV: begin
          if (!ctrl_q.power_on) begin
            state_q <= ST_IDLE;
          end else if (conv_done) begin
            cyc_q <= '0;
            len_q <= NORMAL_LEN;
            if (!free_run) begin
              state_q <= ST_IDLE;
            end
          end else if (tick) begin
            cyc_q <= cyc_q + 5'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_pend_q <= 1'b0;
    end else if (ce) begin
      if (start_now) begin
        init_pend_q <= 1'b0;
      end else if (power_rise) begin
        init_pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converting <= 1'b0;
    end else if (ce) begin
      converting <= (state_q == ST_CONV) ? (ctrl_q.power_on && !(conv_done && !free_run))
                                         : start_now;
    end
  end

  // ---------------------------------------------------------------
  // Deferred channel and reference selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_ch_q <= '0;
      active_ref_q <= '0;
    end else if (ce) begin
      if (state_q == ST_IDLE || conv_done) begin
        active_ch_q <= insel_q.channel_gain_select;
        active_ref_q <= insel_q.ref_select;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_ch <= '0;
      analog_ref <= '0;
    end else if (ce) begin
      analog_ch <= active_ch_q;
      analog_ref <= active_ref_q;
    end
  end

  // ---------------------------------------------------------------
  // Result capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sar_s1_q <= '0;
      sar_s2_q <= '0;
    end else if (ce) begin
      sar_s1_q <= sar_result;
      sar_s2_q <= sar_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (ce) begin
      if (conv_done && !lock_q) begin
        result_q <= is_diff(active_ch_q) ? {~sar_s2_q[RESULT_W-1], sar_s2_q[RESULT_W-2:0]} : sar_s2_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else if (ce) begin
      // low read locks, high read frees
      if (rd_fire && araddr == OFF_RES_HI) begin
        lock_q <= 1'b0;
      end else if (rd_fire && araddr == OFF_RES_LO) begin
        lock_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control and status registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= ctrl_t'(REG_RESET);
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q.power_on <= wctrl.power_on;
        ctrl_q.auto_trigger_enable <= wctrl.auto_trigger_enable;
        ctrl_q.completion_irq_enable <= wctrl.completion_irq_enable;
        ctrl_q.clock_divider_select <= wctrl.clock_divider_select;
      end
      ctrl_q.conversion_start <= 1'b0;
      if (conv_done) begin
        ctrl_q.completion_flag <= 1'b1;
      end else if (irq_ack || (wr_ctrl && wctrl.completion_flag)) begin
        ctrl_q.completion_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      insel_q <= insel_t'(REG_RESET);
      sfio_q <= sfio_t'(REG_RESET);
      gie_q <= 1'b0;
    end else if (ce && wr_fire && wen_q) begin
      if (awaddr_q == OFF_INSEL) begin
        insel_q <= insel_t'(wbyte_q);
      end
      if (awaddr_q == OFF_SFIO) begin
        sfio_q.trigger_source_select <= wbyte_q[7:5];
        sfio_q.other_bits <= wbyte_q[3:0];
      end
      if (awaddr_q == OFF_PSTAT) begin
        gie_q <= wbyte_q[PSTAT_GIE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
    end else if (ce) begin
      irq_req <= ctrl_q.completion_flag && ctrl_q.completion_irq_enable && gie_q && !irq_ack;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      awready <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
        awready <= 1'b0;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
        awready <= 1'b1;
      end else if (!aw_have_q) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_q <= 1'b0;
      wbyte_q <= '0;
      wen_q <= 1'b0;
      wready <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wen_q <= wstrb[0];
        wready <= 1'b0;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
        wready <= 1'b1;
      end else if (!w_have_q) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        case (awaddr_q)
          OFF_CTRL, OFF_RES_LO, OFF_RES_HI, OFF_SFIO, OFF_INSEL, OFF_PSTAT: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;
  logic rd_ok;
  ctrl_t ctrl_view;
  always_comb begin
    ctrl_view = ctrl_q;
    ctrl_view.conversion_start = converting;
    rd_byte = '0;
    rd_ok = 1'b1;
    case (araddr)
      OFF_CTRL: rd_byte = ctrl_view;
      OFF_RES_LO: rd_byte = insel_q.left_adjust ? {result_q[1:0], 6'h00} : result_q[7:0];
      OFF_RES_HI: rd_byte = insel_q.left_adjust ? result_q[9:2] : {6'h00, result_q[9:8]};
      OFF_SFIO: rd_byte = {sfio_q.trigger_source_select, 1'b0, sfio_q.other_bits};
      OFF_INSEL: rd_byte = insel_q;
      OFF_PSTAT: rd_byte = {7'h00, gie_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

endmodule : adc_sequencing_control
`default_nettype wire

// File: tb/adc_seq_partner.sv
`timescale 1ns/100ps
`default_nettype none
module adc_seq_partner (
  input wire logic [4:0] analog_ch,
  input wire logic [9:0] sar_lvl,
  input wire logic [7:1] trig_lvl,
  output logic [9:0] sar_result,
  output logic [7:1] trig_in
);
  // Converter output depends on the selected input, so a wrong channel shows up
  assign sar_result = {analog_ch, analog_ch} ^ sar_lvl;
  assign trig_in = trig_lvl;
endmodule : adc_seq_partner
`default_nettype wire

// File: tb/adc_seq_props.sv
`timescale 1ns/100ps
`default_nettype none
module adc_seq_props
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic converting
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  assign ctrl_wr = awvalid && awready && wvalid && wready && ce && wstrb[0] && awaddr == OFF_CTRL;

  a_start_runs: assert property (ctrl_wr && wdata[7:6] == 2'b11 && !converting |-> ##[1:3] converting)
    else $error("start write did not begin a conversion");
  a_power_off_abort: assert property (ctrl_wr && !wdata[7] |-> ##[1:4] !converting)
    else $error("power off did not stop the conversion");
  a_conv_min_len: assert property ($rose(converting) |-> converting [*8])
    else $error("conversion ended too early");
  a_ack_drops_irq: assert property (irq_ack && ce |=> !irq_req)
    else $error("interrupt request stayed after vector taken");
  a_reserved_zero: assert property (arvalid && arready && araddr == OFF_SFIO |=> rdata[4] == 1'b0)
    else $error("reserved bit read as one");
  a_start_readback: assert property (arvalid && arready && araddr == OFF_CTRL |=> rdata[6] == $past(converting))
    else $error("start bit readback differs from busy state");
  a_unmapped_read: assert property (arvalid && arready && araddr > OFF_PSTAT |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
endmodule : adc_seq_props

bind adc_sequencing_control adc_seq_props adc_seq_props_inst (
  .clk(clk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .irq_ack(irq_ack), .irq_req(irq_req), .converting(converting)
);
`default_nettype wire

// File: tb/adc_sequencing_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adc_sequencing_control_bench;
  import adc_seq_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, irq_ack = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq_req, converting;
  logic [1:0] bresp, rresp, rs;
  logic [7:1] trig_lvl = 0, trig_in;
  logic [9:0] sar_lvl = 10'h2A5, sar_result, r;
  logic [4:0] analog_ch, code;
  logic [4:0] codes [6] = '{5'h07, 5'h08, 5'h0F, 5'h1D, 5'h1E, 5'h1F};
  int n_mismatch = 0, tests_run = 0, cyc = 0, n;

  always #2.5 clk = ~clk;

  adc_sequencing_control #(.FIRST_CYCLES(25), .NORMAL_CYCLES(13)) adc_sequencing_control_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .trig_in(trig_in), .sar_result(sar_result), .irq_ack(irq_ack),
    .irq_req(irq_req), .analog_ch(analog_ch), .analog_ref(), .converting(converting)
  );
  adc_seq_partner adc_seq_partner_inst (
    .analog_ch(analog_ch), .sar_lvl(sar_lvl), .trig_lvl(trig_lvl), .sar_result(sar_result), .trig_in(trig_in)
  );

  // --------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    @(posedge clk);
    while (awvalid || wvalid) begin
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      @(posedge clk);
    end
    while (!bvalid) @(posedge clk);
    rs = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 0;
    while (!rvalid) @(posedge clk);
    rv = rdata;
    rs = rresp;
    rready <= 0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
    rd(a);
    chk(s, e, rv);
  endtask : rc

  task automatic run(output int len);
    len = 0;
    while (!converting) @(posedge clk);
    while (converting) begin
      @(posedge clk);
      len++;
    end
  endtask : run

  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // --------------------------------------------------
  // Test sequence
  // --------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 6; i++) rc(8'(i * 4), 32'h0, "reset value");
    wstrb <= 4'h0;
    wr(OFF_INSEL, 8'h1F);
    wstrb <= 4'hF;
    rc(OFF_INSEL, 32'h0, "masked write");
    rd(8'h20);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rs));
    wr(8'h20, 8'hFF);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rs));
    wr(OFF_SFIO, 8'hFF);
    rc(OFF_SFIO, 32'h0000_00EF, "sfio");
    wr(OFF_SFIO, 8'h00);
    wr(OFF_PSTAT, 8'h01);
    wr(OFF_INSEL, 8'h03);
    wr(OFF_CTRL, 8'hC8);
    rc(OFF_CTRL, 32'h0000_00C8, "start busy");
    wr(OFF_INSEL, 8'h05);
    chk("deferred channel", 32'h3, 32'(analog_ch));
    run(n);
    chk("first length", 32'h1, 32'(n > 30 && n <= 50));
    @(posedge clk);
    chk("channel after", 32'h5, 32'(analog_ch));
    rc(OFF_CTRL, 32'h0000_0098, "flag");
    chk("irq", 32'h1, 32'(irq_req));
    r = {5'd3, 5'd3} ^ sar_lvl;
    rc(OFF_RES_LO, 32'(r[7:0]), "res lo");
    rc(OFF_RES_HI, 32'(r[9:8]), "res hi");
    wr(OFF_CTRL, 8'h98);
    rc(OFF_CTRL, 32'h0000_0088, "flag clear");
    wr(OFF_CTRL, 8'hC8);
    run(n);
    chk("later length", 32'h1, 32'(n >= 18 && n <= 28));
    wr(OFF_PSTAT, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq_req));
    wr(OFF_PSTAT, 8'h01);
    irq_ack <= 1;
    @(posedge clk);
    irq_ack <= 0;
    repeat (2) @(posedge clk);
    chk("irq after ack", 32'h0, 32'(irq_req));
    rc(OFF_CTRL, 32'h0000_0088, "flag after ack");
    for (int i = 0; i < 6; i++) begin
      code = codes[i];
      wr(OFF_INSEL, {3'b001, code});
      wr(OFF_CTRL, 8'hC8);
      run(n);
      r = {code, code} ^ sar_lvl ^ ((code >= CH_DIFF_FIRST && code <= CH_DIFF_LAST) ? 10'h200 : 10'h0);
      rc(OFF_RES_LO, 32'({r[1:0], 6'h0}), "left lo");
      rc(OFF_RES_HI, 32'(r[9:2]), "left hi");
    end
    wr(OFF_INSEL, 8'h1F);
    rc(OFF_RES_LO, 32'(r[7:0]), "right lo");
    rc(OFF_RES_HI, 32'(r[9:8]), "right hi");
    rd(OFF_RES_LO);
    sar_lvl <= 10'h0F0;
    wr(OFF_CTRL, 8'hC8);
    run(n);
    rc(OFF_RES_LO, 32'(r[7:0]), "locked lo");
    rc(OFF_RES_HI, 32'(r[9:8]), "locked hi");
    r = {5'h1F, 5'h1F} ^ 10'h0F0;
    wr(OFF_CTRL, 8'hC8);
    run(n);
    rc(OFF_RES_LO, 32'(r[7:0]), "unlocked lo");
    rc(OFF_RES_HI, 32'(r[9:8]), "unlocked hi");
    wr(OFF_CTRL, 8'hCA);
    run(n);
    chk("divide by four", 32'h1, 32'(n >= 45 && n <= 56));
    wr(OFF_CTRL, 8'hC8);
    ce <= 0;
    repeat (60) @(posedge clk);
    chk("frozen by enable", 32'h1, 32'(converting));
    ce <= 1;
    run(n);
    wr(OFF_CTRL, 8'h98);
    wr(OFF_CTRL, 8'hC8);
    repeat (10) @(posedge clk);
    wr(OFF_CTRL, 8'h08);
    repeat (2) @(posedge clk);
    chk("aborted", 32'h0, 32'(converting));
    rc(OFF_CTRL, 32'h0000_0008, "abort no flag");
    wr(OFF_CTRL, 8'h80);
    wr(OFF_SFIO, 8'h60);
    trig_lvl <= 7'h04;
    repeat (4) @(posedge clk);
    chk("trigger ignored", 32'h0, 32'(converting));
    trig_lvl <= 7'h00;
    wr(OFF_CTRL, 8'hA0);
    for (int k = 1; k < 8; k++) begin
      wr(OFF_SFIO, {3'(k), 5'h0});
      trig_lvl[k] <= 1'b1;
      repeat (4) @(posedge clk);
      chk("trigger start", 32'h1, 32'(converting));
      run(n);
      trig_lvl <= 7'h00;
    end
    trig_lvl <= 7'h02;
    wr(OFF_SFIO, 8'h20);
    wr(OFF_SFIO, 8'h40);
    repeat (4) @(posedge clk);
    chk("source switch", 32'h1, 32'(converting));
    run(n);
    trig_lvl <= 7'h00;
    wr(OFF_SFIO, 8'h00);
    repeat (6) @(posedge clk);
    chk("free run switch", 32'h0, 32'(converting));
    wr(OFF_CTRL, 8'hE0);
    repeat (100) @(posedge clk);
    chk("free running", 32'h1, 32'(converting));
    wr(OFF_CTRL, 8'h00);
    report_and_stop();
  end
endmodule : adc_sequencing_control_bench
`default_nettype wire
